// ---- src/dcb_boot_ctrl.sv ----
// boot, reset, memory-map and shared external interface control for two subsystems
//
// The placing of the registers and the address-and-strobe port are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
// Function
// R01: each subsystem has 256K program, 64K data, 64K io spaces of 16-bit words
// R02: dual-access ram data-only after reset; low overlay adds program visibility
// R03: single-access ram 4000h-7FFFh data-only; low overlay adds program space
// R04: single-access ram 8000h-FFFFh program-only; high overlay adds data space
// R05: ram at 18000h-1FFFFh and 2F000h-2FFFFh is program-only, never data
// R06: extended program space is four 64K pages on an 18-bit address
// R07: data addresses inside ram bounds internal, others start external access
// R08: 64K io ports per subsystem; io strobe marks io reads and writes
// R09: shared interface goes to subsystem A when owner pin low, B when high
// R10: interface-select high gives external memory, low gives host port
// R11: external memory accesses happen only with interface-select high
// R12: 16-bit mode register: vector pointer 15-7, control bits 6-0
// R13: program-select bit maps x8000-xFFFF of every page external or internal; the code applies it to page 0 only
// R14: reset value of program-select bits follows interface, mux and owner pins
// R15: subsystem reset clears its registers; A also resets pll, bypass clock
// R16: host waits three cycles after host port reset rises before accessing
// R17: cores fetch reset vector at FF80h after release; no boot loader
// R18: host boot only with interface-select low, device held in reset
// R19: resets held low over host port reset rise release together or A first
// R20: resets high at host port reset rise hold cores; write 2Fh releases one
// R21: interface-select and mux mode high connect master bus to slave host port
// R22: select high, mux low runs both cores in lockstep; later writes blocked
// R23: simultaneous boot ties resets high; both fetch vector at host reset rise
// R24: sequential boot: master copies code, passes ownership, releases slave
// R25: owner pin changes only when no external access is in progress
module dcb_boot_ctrl (
    // clock, reset, enable
    input wire logic core_clk,
    input wire logic srst,
    input wire logic clk_en,
    // device pins
    input wire logic ext_owner_select,
    input wire logic ext_iface_select,
    input wire logic host_port_mux_mode,
    input wire logic sub_a_reset_n,
    input wire logic sub_b_reset_n,
    input wire logic host_port_reset_n,
    // host port release write
    input wire logic hp_wr,
    input wire logic [15:0] hp_addr,
    // software register port
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    // per-subsystem access requests
    input wire logic [1:0] req_valid,
    input wire logic [1:0] req_write,
    input wire logic [3:0] req_space,
    input wire logic [2*dcb_pkg::PROG_AW-1:0] req_addr,
    // per-subsystem decode results
    output logic [1:0] hit_dual_access_ram,
    output logic [1:0] hit_single_access_ram,
    output logic [1:0] ext_wait,
    // shared external interface
    output logic ext_start,
    output logic ext_we,
    output logic ext_prog_strobe,
    output logic ext_data_strobe,
    output logic io_space_strobe,
    output logic [dcb_pkg::PROG_AW-1:0] ext_addr,
    // boot and clock status
    output logic [1:0] core_run,
    output logic [1:0] vec_fetch,
    output logic hp_ready,
    output logic lockstep,
    output logic pll_reset,
    output logic clk_bypass
);
    typedef struct packed {
        logic [1:0][15:0] pmc;
        dcb_pkg::dcb_core_t [1:0] core;
        logic [1:0] hold;
        logic hp_prev;
        logic [1:0] hp_cnt;
        logic hp_ready;
        logic wr_block;
        logic [15:0] rdata;
        logic [1:0] hit_dual_access_ram;
        logic [1:0] hit_single_access_ram;
        logic [1:0] ext_wait;
        logic ext_start;
        logic ext_we;
        logic ext_prog;
        logic ext_data;
        logic ext_io;
        logic [dcb_pkg::PROG_AW-1:0] ext_addr;
        logic [1:0] vec_fetch;
        logic lockstep;
        logic pll_reset;
    } dcb_state_t;

    dcb_state_t st;
    dcb_state_t next_st;
    logic [1:0] rst_n;
    logic [1:0] ipsel_init;
    logic [1:0] want_ext;
    logic [1:0] int_dual_access_ram;
    logic [1:0] int_single_access_ram;
    logic mux_mode;
    logic lock_mode;
    logic hp_rise;
    logic hp_release;
    logic release_target;
    logic owner;

    assign rst_n = {sub_b_reset_n, sub_a_reset_n};
    assign owner = ext_owner_select;
    // R21: both selects high joins master bus to slave host port
    assign mux_mode = ext_iface_select & host_port_mux_mode;
    // R22: select high with mux low means lockstep boot
    assign lock_mode = ext_iface_select & ~host_port_mux_mode;
    assign hp_rise = host_port_reset_n & ~st.hp_prev;

    // R14: program-select reset value from pins
    always_comb
    begin
        if (!ext_iface_select)
            ipsel_init = 2'h0;
        else if (!host_port_mux_mode)
            ipsel_init = 2'h3;
        else
            ipsel_init = owner ? 2'h2 : 2'h1;
    end

    // R20: release write accepted only once the host port has settled
    always_comb
    begin
        hp_release = hp_wr & st.hp_ready & (hp_addr == dcb_pkg::HP_RELEASE_ADDR)
            & (~ext_iface_select | mux_mode);
        // R21: over the joined bus the owner is master, so the other is the slave
        release_target = mux_mode ? ~owner : owner;
    end

    // address decode per subsystem, repeated for both cores
    for (genvar i = 0; i < 2; i++)
    begin : g_dec
        logic [dcb_pkg::PROG_AW-1:0] a;
        logic [15:0] lo;
        logic [1:0] pg;
        logic [1:0] sp;
        logic ovl;
        logic dovl;
        logic ipsel;
        assign a = req_addr[i*dcb_pkg::PROG_AW +: dcb_pkg::PROG_AW];
        // R06: page number from the two top lines of the 18-bit address
        assign lo = a[15:0];
        assign pg = a[17:16];
        assign sp = req_space[2*i +: 2];
        assign ovl = st.pmc[i][dcb_pkg::PMC_LOVLY];
        assign dovl = st.pmc[i][dcb_pkg::PMC_HDOVLY];
        assign ipsel = st.pmc[i][dcb_pkg::PMC_IPSEL];
        always_comb
        begin
            int_dual_access_ram[i] = 1'b0;
            int_single_access_ram[i] = 1'b0;
            if (sp == dcb_pkg::SPACE_DATA)
            begin
                // R02: dual-access ram always in data space
                int_dual_access_ram[i] = (lo >= dcb_pkg::DUAL_ACCESS_RAM_LO) && (lo <= dcb_pkg::DUAL_ACCESS_RAM_HI);
                // R03: low single-access ram data space
                // R04: high single-access ram in data only with high overlay
                int_single_access_ram[i] = ((lo > dcb_pkg::DUAL_ACCESS_RAM_HI) && (lo <= dcb_pkg::SINGLE_ACCESS_RAM_LO_HI))
                    || (dovl && (lo >= dcb_pkg::UPPER_LO));
            end
            else if (sp == dcb_pkg::SPACE_PROG)
            begin
                if (lo < dcb_pkg::UPPER_LO)
                begin
                    // R02: low overlay maps ram into page 0 program space
                    int_dual_access_ram[i] = ovl && (pg == 2'h0) && (lo >= dcb_pkg::DUAL_ACCESS_RAM_LO)
                        && (lo <= dcb_pkg::DUAL_ACCESS_RAM_HI);
                    // R03: low overlay also brings 4000h-7FFFh to program
                    int_single_access_ram[i] = ovl && (pg == 2'h0) && (lo > dcb_pkg::DUAL_ACCESS_RAM_HI);
                end
                else
                begin
                    // R13: program-select low keeps page 0 x8000-xFFFF internal
                    // R05: the upper page 1 and 2F000h block are always program ram
                    int_single_access_ram[i] = (!ipsel && (pg == 2'h0))
                        || ((a >= dcb_pkg::SINGLE_ACCESS_RAM_P1_LO) && (a <= dcb_pkg::SINGLE_ACCESS_RAM_P1_HI))
                        || ((a >= dcb_pkg::SINGLE_ACCESS_RAM_P2_LO) && (a <= dcb_pkg::SINGLE_ACCESS_RAM_P2_HI));
                end
            end
            // R07: from a running core, any program, data or io request not served on chip goes out, io always does
            want_ext[i] = req_valid[i] && !int_dual_access_ram[i] && !int_single_access_ram[i]
                && (sp != 2'h3) && (st.core[i] == dcb_pkg::CORE_RUN);
        end
    end

    // next state of the whole block
    always_comb
    begin
        logic [1:0] grant;
        logic sel;
        grant = 2'h0;
        sel = 1'b0;
        next_st = st;
        next_st.hp_prev = host_port_reset_n;
        next_st.vec_fetch = 2'h0;
        next_st.ext_start = 1'b0;
        next_st.ext_we = 1'b0;
        next_st.ext_prog = 1'b0;
        next_st.ext_data = 1'b0;
        next_st.ext_io = 1'b0;
        next_st.rdata = 16'h0000;
        next_st.lockstep = lock_mode;
        // R15: pll held in reset and clock in bypass while A reset is low
        next_st.pll_reset = ~sub_a_reset_n;

        // R16: host port usable four cycles after its reset rises (three counted, then ready)
        if (!host_port_reset_n)
        begin
            next_st.hp_cnt = 2'h0;
            next_st.hp_ready = 1'b0;
        end
        else if (st.hp_cnt != dcb_pkg::HP_SETTLE_CYCLES)
            next_st.hp_cnt = st.hp_cnt + 2'h1;
        else
            next_st.hp_ready = 1'b1;

        for (int i = 0; i < 2; i++)
        begin
            // R20: resets high at host port reset rise keeps the cores halted
            // R23: in lockstep boot no hold, both fetch the vector together
            if (hp_rise && (&rst_n) && !lock_mode)
                next_st.hold[i] = 1'b1;
            else if (hp_release && (release_target == i[0]))
                next_st.hold[i] = 1'b0;
            else if (!rst_n[i])
                next_st.hold[i] = 1'b0;
            unique case (st.core[i])
                dcb_pkg::CORE_HALT:
                begin
                    // R18: a core stays halted while the host holds it in reset
                    // R19: each core leaves on its own reset release
                    if (rst_n[i] && host_port_reset_n && !next_st.hold[i] && !st.hold[i])
                        next_st.core[i] = dcb_pkg::CORE_VECTOR;
                end
                dcb_pkg::CORE_VECTOR:
                begin
                    // R17: one vector fetch at FF80h then run
                    next_st.vec_fetch[i] = 1'b1;
                    next_st.core[i] = dcb_pkg::CORE_RUN;
                end
                dcb_pkg::CORE_RUN:
                begin
                end
            endcase
            // R15: a low subsystem reset clears its state
            // R24: the slave may sit here while the master boots
            if (!rst_n[i] || !host_port_reset_n)
                next_st.core[i] = dcb_pkg::CORE_HALT;
            if (!rst_n[i])
            begin
                next_st.pmc[i] = {dcb_pkg::PMC_VPTR_RST, 7'h00};
                next_st.pmc[i][dcb_pkg::PMC_IPSEL] = ipsel_init[i];
            end
        end

        // R12: full 16-bit read/write mode registers
        if (reg_wr)
        begin
            if (reg_addr == dcb_pkg::REG_PMC_A)
                next_st.pmc[0] = reg_wdata;
            else if (reg_addr == dcb_pkg::REG_PMC_B)
                next_st.pmc[1] = reg_wdata;
            else if (reg_addr == dcb_pkg::REG_CTRL)
                next_st.wr_block = reg_wdata[0];
        end
        if (reg_rd)
        begin
            unique case (reg_addr)
                dcb_pkg::REG_PMC_A: next_st.rdata = st.pmc[0];
                dcb_pkg::REG_PMC_B: next_st.rdata = st.pmc[1];
                dcb_pkg::REG_CTRL: next_st.rdata = {15'h0000, st.wr_block};
                dcb_pkg::REG_STATUS: next_st.rdata = {6'h00, st.hold, st.hp_ready,
                    st.lockstep, owner, ext_iface_select,
                    st.core[1] == dcb_pkg::CORE_RUN, st.core[0] == dcb_pkg::CORE_RUN,
                    st.vec_fetch};
                default: next_st.rdata = 16'h0000;
            endcase
        end

        // R09: owner pin grants the shared interface
        // R25: owner pin is taken as steady across a bus cycle
        grant[owner] = 1'b1;
        sel = owner;
        // R01: internal ram hits per space reported per core
        next_st.hit_dual_access_ram = int_dual_access_ram & req_valid;
        next_st.hit_single_access_ram = int_single_access_ram & req_valid;
        // R10: host port mode leaves no external memory cycles
        // R11: external cycles only with interface-select high
        next_st.ext_wait = want_ext & ~(grant & {2{ext_iface_select}});
        if (want_ext[sel] && ext_iface_select)
        begin
            next_st.ext_start = 1'b1;
            // R22: writes blocked in lockstep once code has been moved
            next_st.ext_we = req_write[sel] && !(lock_mode && st.wr_block);
            next_st.ext_addr = req_addr[sel*dcb_pkg::PROG_AW +: dcb_pkg::PROG_AW]
                & dcb_pkg::PROG_WORDS_M1;
            next_st.ext_prog = req_space[2*sel +: 2] == dcb_pkg::SPACE_PROG;
            next_st.ext_data = req_space[2*sel +: 2] == dcb_pkg::SPACE_DATA;
            // R08: io strobe marks io space cycles, all 18 request address lines passed on
            next_st.ext_io = req_space[2*sel +: 2] == dcb_pkg::SPACE_IO;
        end
    end

    // state register with freeze on clock enable
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            st <= '0;
            st.pmc[0] <= {dcb_pkg::PMC_VPTR_RST, 7'h00};
            st.pmc[1] <= {dcb_pkg::PMC_VPTR_RST, 7'h00};
            // R14: pins sampled during device reset
            st.pmc[0][dcb_pkg::PMC_IPSEL] <= ipsel_init[0];
            st.pmc[1][dcb_pkg::PMC_IPSEL] <= ipsel_init[1];
            // idle level of the host reset pin, so leaving srst is not taken as a rise
            st.hp_prev <= 1'b1;
            st.pll_reset <= 1'b1;
        end
        else if (clk_en)
        begin
            st <= next_st;
        end
    end

    // outputs straight from the state register
    assign reg_rdata = st.rdata;
    assign hit_dual_access_ram = st.hit_dual_access_ram;
    assign hit_single_access_ram = st.hit_single_access_ram;
    assign ext_wait = st.ext_wait;
    assign ext_start = st.ext_start;
    assign ext_we = st.ext_we;
    assign ext_prog_strobe = st.ext_prog;
    assign ext_data_strobe = st.ext_data;
    assign io_space_strobe = st.ext_io;
    assign ext_addr = st.ext_addr;
    assign core_run = {st.core[1] == dcb_pkg::CORE_RUN, st.core[0] == dcb_pkg::CORE_RUN};
    assign vec_fetch = st.vec_fetch;
    assign hp_ready = st.hp_ready;
    assign lockstep = st.lockstep;
    assign pll_reset = st.pll_reset;
    assign clk_bypass = st.pll_reset;
endmodule
`default_nettype wire

// ---- src/dcb_pkg.sv ----
// constants and types for the dual-core boot and external-select block
package dcb_pkg;
    // software register indices on the plain register port
    localparam logic [3:0] REG_PMC_A = 4'h0;
    localparam logic [3:0] REG_PMC_B = 4'h1;
    localparam logic [3:0] REG_CTRL = 4'h2;
    localparam logic [3:0] REG_STATUS = 4'h3;
    // processor mode config field positions
    localparam int PMC_VPTR_LSB = 7;
    localparam int PMC_IPSEL = 6;
    localparam int PMC_LOVLY = 5;
    localparam int PMC_ADDRESS_VISIBILITY = 4;
    localparam int PMC_HDOVLY = 3;
    localparam int PMC_CLOCK_OUTPUT_DISABLE = 2;
    localparam int PMC_MULTIPLY_SATURATION = 1;
    localparam int PMC_SST = 0;
    // vector pointer after reset places the vector page at FF80h
    localparam logic [8:0] PMC_VPTR_RST = 9'h1FF;
    localparam logic [15:0] RESET_VECTOR = 16'hFF80;
    // address spaces per subsystem
    localparam int PROG_AW = 18;
    localparam int DATA_AW = 16;
    localparam logic [PROG_AW-1:0] PROG_WORDS_M1 = 18'h3FFFF;
    localparam logic [1:0] SPACE_PROG = 2'h0;
    localparam logic [1:0] SPACE_DATA = 2'h1;
    localparam logic [1:0] SPACE_IO = 2'h2;
    // on-chip ram bounds within a 64K page, then the two 18-bit program ram ranges
    localparam logic [15:0] DUAL_ACCESS_RAM_LO = 16'h0060;
    localparam logic [15:0] DUAL_ACCESS_RAM_HI = 16'h3FFF;
    localparam logic [15:0] SINGLE_ACCESS_RAM_LO_HI = 16'h7FFF;
    localparam logic [15:0] UPPER_LO = 16'h8000;
    localparam logic [PROG_AW-1:0] SINGLE_ACCESS_RAM_P1_LO = 18'h18000;
    localparam logic [PROG_AW-1:0] SINGLE_ACCESS_RAM_P1_HI = 18'h1FFFF;
    localparam logic [PROG_AW-1:0] SINGLE_ACCESS_RAM_P2_LO = 18'h2F000;
    localparam logic [PROG_AW-1:0] SINGLE_ACCESS_RAM_P2_HI = 18'h2FFFF;
    // host port release address and settle time
    localparam logic [15:0] HP_RELEASE_ADDR = 16'h002F;
    localparam logic [1:0] HP_SETTLE_CYCLES = 2'h3;
    // per-core boot state
    typedef enum logic [1:0] {
        CORE_HALT,
        CORE_VECTOR,
        CORE_RUN
    } dcb_core_t;
endpackage

// ---- dv/dcb_boot_ctrl_assertions.sv ----
// port-level checks for the dual-core boot and external-select controller
`timescale 1ns/100ps
`default_nettype none
module dcb_boot_ctrl_assertions (
    // clock and reset
    input wire logic core_clk,
    input wire logic srst,
    // pins
    input wire logic ext_owner_select,
    input wire logic ext_iface_select,
    input wire logic host_port_mux_mode,
    input wire logic sub_a_reset_n,
    input wire logic host_port_reset_n,
    // access requests
    input wire logic [1:0] req_valid,
    input wire logic [3:0] req_space,
    input wire logic [2*dcb_pkg::PROG_AW-1:0] req_addr,
    // decode and bus outputs
    input wire logic [1:0] hit_dual_access_ram,
    input wire logic ext_start,
    input wire logic io_space_strobe,
    // boot and clock status
    input wire logic [1:0] core_run,
    input wire logic [1:0] vec_fetch,
    input wire logic hp_ready,
    input wire logic lockstep,
    input wire logic pll_reset,
    input wire logic clk_bypass
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);
    property p_iface; ext_start |-> $past(ext_iface_select); endproperty
    a_iface: assert property (p_iface) else $error("bus cycle in host port mode");
    property p_owner; ext_start |-> $past(ext_owner_select ? req_valid[1] : req_valid[0]); endproperty
    a_owner: assert property (p_owner) else $error("bus cycle without owner request");
    property p_io; io_space_strobe |-> ext_start &&
        $past(ext_owner_select ? req_space[3:2] : req_space[1:0]) == dcb_pkg::SPACE_IO; endproperty
    a_io: assert property (p_io) else $error("io strobe without io request");
    property p_pll; !srst |=> pll_reset == !$past(sub_a_reset_n) && clk_bypass == pll_reset; endproperty
    a_pll: assert property (p_pll) else $error("pll reset or bypass wrong");
    property p_vec; vec_fetch[0] && sub_a_reset_n && host_port_reset_n |=>
        core_run[0] && !vec_fetch[0]; endproperty
    a_vec: assert property (p_vec) else $error("core A did not run after vector");
    property p_hp_wait; $rose(host_port_reset_n) |-> !hp_ready[*3] ##[1:3] hp_ready; endproperty
    a_hp_wait: assert property (p_hp_wait) else $error("host port ready timing wrong");
    property p_lock; !srst |=> lockstep == $past(ext_iface_select && !host_port_mux_mode); endproperty
    a_lock: assert property (p_lock) else $error("lockstep flag wrong");
    property p_dual_access_ram; core_run[0] && req_valid[0] && req_space[1:0] == dcb_pkg::SPACE_DATA &&
        req_addr[15:0] inside {[dcb_pkg::DUAL_ACCESS_RAM_LO:dcb_pkg::DUAL_ACCESS_RAM_HI]} |=> hit_dual_access_ram[0]; endproperty
    a_dual_access_ram: assert property (p_dual_access_ram) else $error("data ram address not served on chip");
    // main scenarios reached
    c_ext: cover property (ext_start);
    c_io: cover property (io_space_strobe);
    c_vec: cover property (vec_fetch[0]);
endmodule
`default_nettype wire

// ---- dv/dcb_host_model.sv ----
// behavioural external host driving the host port reset and release write
`timescale 1ns/100ps
`default_nettype none
module dcb_host_model (
    // clock
    input wire logic core_clk,
    // host port pins
    output logic host_port_reset_n,
    output logic hp_wr,
    output logic [15:0] hp_addr
);
    // idle address is not the release address
    initial
    begin
        host_port_reset_n = 1'b1;
        hp_wr = 1'b0;
        hp_addr = 16'hFFD0;
    end
    // pulse host reset; gap makes the host prompt or slow
    task automatic host_reset(input int gap);
        @(posedge core_clk);
        host_port_reset_n <= 1'b0;
        repeat (3) @(posedge core_clk);
        host_port_reset_n <= 1'b1;
        repeat (3 + gap) @(posedge core_clk);
    endtask
    // one-cycle write; address inverted after so nothing stale looks valid
    task automatic host_write(input logic [15:0] addr);
        hp_wr <= 1'b1;
        hp_addr <= addr;
        @(posedge core_clk);
        hp_wr <= 1'b0;
        hp_addr <= ~addr;
    endtask
endmodule
`default_nettype wire

// ---- dv/tb_top.sv ----
// self-checking bench for the dual-core boot and external-select controller
`timescale 1ns/100ps
`default_nettype none
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin err_total++; \
    $display("MISMATCH t=%0t got=%0h exp=%0h", $time, got, exp); end end
module tb_top;
    logic core_clk = 1'b0;
    logic srst = 1'b1;
    logic owner = 1'b0;
    logic iface = 1'b1;
    logic mux = 1'b1;
    logic a_rst_n = 1'b1;
    logic b_rst_n = 1'b1;
    logic [3:0] reg_addr = 4'h0;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [1:0] req_valid = 2'h0;
    logic [1:0] req_write = 2'h0;
    logic [3:0] req_space = 4'hF;
    logic [35:0] req_addr = 36'h0;
    logic hp_wr, hprst_n, ext_start, ext_we, prog_stb, data_stb, io_stb;
    logic hp_ready, lockstep, pll_reset, clk_bypass;
    logic [15:0] hp_addr, reg_rdata;
    logic [17:0] ext_addr;
    logic [1:0] hit_dual_access_ram, hit_single_access_ram, ext_wait, core_run, vec_fetch;
    int err_total = 0;
    int check_count = 0;
    int cyc = 0;
    // 10 MHz core clock
    always #50 core_clk = ~core_clk;
    dcb_host_model host (.core_clk(core_clk), .host_port_reset_n(hprst_n), .hp_wr(hp_wr),
        .hp_addr(hp_addr));
    dcb_boot_ctrl uut (.core_clk(core_clk), .srst(srst), .clk_en(1'b1),
        .ext_owner_select(owner), .ext_iface_select(iface), .host_port_mux_mode(mux),
        .sub_a_reset_n(a_rst_n), .sub_b_reset_n(b_rst_n), .host_port_reset_n(hprst_n),
        .hp_wr(hp_wr), .hp_addr(hp_addr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .req_valid(req_valid),
        .req_write(req_write), .req_space(req_space), .req_addr(req_addr),
        .hit_dual_access_ram(hit_dual_access_ram), .hit_single_access_ram(hit_single_access_ram), .ext_wait(ext_wait),
        .ext_start(ext_start), .ext_we(ext_we), .ext_prog_strobe(prog_stb),
        .ext_data_strobe(data_stb), .io_space_strobe(io_stb), .ext_addr(ext_addr),
        .core_run(core_run), .vec_fetch(vec_fetch), .hp_ready(hp_ready),
        .lockstep(lockstep), .pll_reset(pll_reset), .clk_bypass(clk_bypass));
    // register port: one-cycle strobes, read data in the next cycle only
    task automatic reg_write(input logic [3:0] a, input logic [15:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic reg_check(input logic [3:0] a, input logic [15:0] exp);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 `CHK(reg_rdata, exp)
    endtask
    // one-cycle access request; outputs are registered at the taking edge
    task automatic req(input int c, input logic [1:0] sp, input logic [17:0] ad, input logic w);
        req_valid[c] <= 1'b1;
        req_write[c] <= w;
        req_space[2*c+:2] <= sp;
        req_addr[18*c+:18] <= ad;
        @(posedge core_clk);
        req_valid <= 2'h0;
        req_space <= 4'hF;
        #1;
    endtask
    // every pin row of the program-select table, then register access kinds
    task automatic s_modes();
        logic [4:0] rows [4] = '{5'b000_00, 5'b100_11, 5'b111_01, 5'b110_10};
        for (int i = 0; i < 4; i++)
        begin
            {iface, mux, owner} <= rows[i][4:2];
            srst <= 1'b1;
            repeat (4) @(posedge core_clk);
            srst <= 1'b0;
            reg_check(dcb_pkg::REG_PMC_A, {9'h1FF, rows[i][1], 6'h00});
            reg_check(dcb_pkg::REG_PMC_B, {9'h1FF, rows[i][0], 6'h00});
            `CHK(lockstep, rows[i][4] & ~rows[i][3])
        end
        reg_write(4'h9, 16'h1234);
        reg_check(4'h9, 16'h0000);
        reg_write(dcb_pkg::REG_PMC_B, 16'hFF97);
        reg_check(dcb_pkg::REG_PMC_B, 16'hFF97);
        `CHK(core_run, 2'h3)
    endtask
    // decode of data, program and io space, ownership and interface select
    task automatic s_decode();
        req(0, dcb_pkg::SPACE_DATA, 18'h09000, 1'b1);
        `CHK({ext_start, ext_we, data_stb, ext_addr}, {3'h7, 18'h09000})
        reg_write(dcb_pkg::REG_PMC_A, 16'hFFC8);
        req(0, dcb_pkg::SPACE_DATA, 18'h09000, 1'b0);
        `CHK({hit_single_access_ram[0], ext_start}, 2'h2)
        req(0, dcb_pkg::SPACE_DATA, 18'h00100, 1'b0);
        `CHK(hit_dual_access_ram[0], 1'b1)
        req(0, dcb_pkg::SPACE_PROG, 18'h00100, 1'b0);
        `CHK({hit_dual_access_ram[0], ext_start, prog_stb}, 3'h3)
        req(0, dcb_pkg::SPACE_DATA, 18'h04000, 1'b0);
        `CHK(hit_single_access_ram[0], 1'b1)
        req(0, dcb_pkg::SPACE_PROG, 18'h18000, 1'b0);
        `CHK({hit_single_access_ram[0], ext_start}, 2'h2)
        req(0, dcb_pkg::SPACE_IO, 18'h01234, 1'b0);
        `CHK({ext_start, io_stb, ext_addr[15:0]}, {2'h3, 16'h1234})
        req(1, dcb_pkg::SPACE_DATA, 18'h09000, 1'b0);
        `CHK({ext_start, ext_wait[1]}, 2'h1)
        owner <= 1'b1;
        req(1, dcb_pkg::SPACE_DATA, 18'h09000, 1'b0);
        `CHK({ext_start, ext_wait[1]}, 2'h2)
        iface <= 1'b0;
        req(1, dcb_pkg::SPACE_DATA, 18'h09000, 1'b0);
        `CHK({ext_start, ext_wait[1]}, 2'h1)
    endtask
    // subsystem resets: registers reload, pll held, cores restart
    task automatic s_pll();
        a_rst_n <= 1'b0;
        b_rst_n <= 1'b0;
        repeat (2) @(posedge core_clk);
        #1 `CHK({pll_reset, clk_bypass, core_run}, 4'hC)
        reg_check(dcb_pkg::REG_PMC_A, 16'hFF80);
        a_rst_n <= 1'b1;
        b_rst_n <= 1'b1;
        repeat (4) @(posedge core_clk);
        #1 `CHK({pll_reset, clk_bypass, core_run}, 4'h3)
    endtask
    // host boot with interface select low: held cores released by writes
    task automatic s_host();
        owner <= 1'b0;
        host.host_reset(2);
        #1 `CHK(core_run, 2'h0)
        `CHK(hp_ready, 1'b1)
        host.host_write(16'h002F);
        repeat (3) @(posedge core_clk);
        #1 `CHK(core_run, 2'h1)
        owner <= 1'b1;
        host.host_write(16'h002F);
        repeat (3) @(posedge core_clk);
        #1 `CHK(core_run, 2'h3)
    endtask
    // lockstep boot: writes pass until the control bit blocks them
    task automatic s_lock();
        iface <= 1'b1;
        mux <= 1'b0;
        owner <= 1'b0;
        req(0, dcb_pkg::SPACE_DATA, 18'h09000, 1'b1);
        `CHK({ext_start, ext_we, lockstep}, 3'h7)
        reg_write(dcb_pkg::REG_CTRL, 16'h0001);
        reg_check(dcb_pkg::REG_CTRL, 16'h0001);
        req(0, dcb_pkg::SPACE_DATA, 18'h09000, 1'b1);
        `CHK({ext_start, ext_we, lockstep}, 3'h5)
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial
    begin
        repeat (4) @(posedge core_clk);
        srst <= 1'b0;
        s_modes();
        s_decode();
        s_pll();
        s_host();
        s_lock();
        end_of_test();
    end
    // hang guard: the run needs under a hundred cycles
    always @(posedge core_clk)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            err_total++;
            end_of_test();
        end
    end
endmodule
bind dcb_boot_ctrl dcb_boot_ctrl_assertions u_chk (.core_clk, .srst, .ext_owner_select,
    .ext_iface_select, .host_port_mux_mode, .sub_a_reset_n, .host_port_reset_n, .req_valid,
    .req_space, .req_addr, .hit_dual_access_ram, .ext_start, .io_space_strobe, .core_run, .vec_fetch,
    .hp_ready, .lockstep, .pll_reset, .clk_bypass);
`default_nettype wire
